// ---- verilog/guard_pkg.sv ----
// Purpose: Shared constants for the stack limit and secure RAM guard.
// Assumes: 16-bit data space addresses, word-aligned stack.
// Notes: Register byte address is four times the register index.
package guard_pkg;

  // ****************************************
  // Register indexes and byte addresses
  // ****************************************
  localparam logic [15:0] BOOT_RAM_CTRL_IDX = 16'h0750;
  localparam logic [15:0] SECURE_RAM_CTRL_IDX = 16'h0752;
  localparam logic [15:0] STACK_LIMIT_IDX = 16'h0780;
  localparam logic [15:0] STACK_PTR_IDX = 16'h0782;
  localparam logic [15:0] ERR_STATUS_IDX = 16'h0784;
  localparam logic [17:0] BOOT_RAM_CTRL_ADDR = {BOOT_RAM_CTRL_IDX, 2'b00};
  localparam logic [17:0] SECURE_RAM_CTRL_ADDR = {SECURE_RAM_CTRL_IDX, 2'b00};
  localparam logic [17:0] STACK_LIMIT_ADDR = {STACK_LIMIT_IDX, 2'b00};
  localparam logic [17:0] STACK_PTR_ADDR = {STACK_PTR_IDX, 2'b00};
  localparam logic [17:0] ERR_STATUS_ADDR = {ERR_STATUS_IDX, 2'b00};

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int LOCK_BIT = 0;
  localparam int READ_GUARD_BIT = 1;
  localparam int WRITE_GUARD_BIT = 2;
  localparam logic [2:0] RAM_CTRL_RESET = 3'h0;
  localparam int OVF_BIT = 0;
  localparam int UNF_BIT = 1;
  localparam int BOOT_VIOL_BIT = 2;
  localparam int SEC_VIOL_BIT = 3;
  localparam logic [15:0] STACK_FLOOR = 16'h0800;
  localparam logic [15:0] STACK_PTR_RESET = 16'h0800;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [7:0] PC_MSB_MASK = 8'h7F;

  // ****************************************
  // Operation and segment codes
  // ****************************************
  typedef enum logic [1:0] {OP_PUSH, OP_POP, OP_EA} stack_op_t;
  typedef enum logic [1:0] {PUSH_DATA, PUSH_CALL, PUSH_EXC} push_kind_t;
  typedef enum logic [1:0] {SEG_GENERAL, SEG_BOOT, SEG_SECURE} fetch_seg_t;

endpackage : guard_pkg

// ---- verilog/stack_guard.sv ----
// Purpose: Software stack pointer with limit and floor checks, plus secure RAM guards.
// Assumes: CPU-side inputs are on clk; APB slave adds one wait state.
// Notes: The stack limit has no reset value; software loads it first.

module stack_guard #(
  parameter logic [15:0] BOOT_RAM_BASE = 16'h0800,
  parameter logic [15:0] BOOT_RAM_END = 16'h08FF,
  parameter logic [15:0] SECURE_RAM_BASE = 16'h0900,
  parameter logic [15:0] SECURE_RAM_END = 16'h09FF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Stack requests from the address generators
  input wire logic stack_req,
  input wire guard_pkg::stack_op_t stack_op,
  input wire guard_pkg::push_kind_t push_kind,
  input wire logic [15:0] push_data,
  input wire logic [7:0] pc_msb_byte,
  input wire logic [7:0] status_low_byte,
  input wire logic [15:0] effective_address,
  // Stack results
  output logic [15:0] stack_pointer_reg,
  output logic stack_mem_we,
  output logic stack_mem_re,
  output logic [15:0] stack_mem_addr,
  output logic [15:0] stack_mem_wdata,
  output logic stack_trap,
  // Data RAM guard
  input wire logic ram_req,
  input wire logic ram_write,
  input wire logic [15:0] ram_addr,
  input wire guard_pkg::fetch_seg_t fetch_seg,
  output logic ram_grant,
  output logic ram_fault
);

  // ****************************************
  // APB slave
  // ****************************************
  logic ack_q;
  logic wr_en;
  logic rd_first;
  logic [31:0] prdata_q;
  logic hit;
  logic [17:0] byte_addr;
  logic [15:0] stack_limit_reg;
  logic [2:0] boot_ctrl_q;
  logic [2:0] sec_ctrl_q;
  logic [3:0] err_q;
  logic [3:0] err_set;

  assign byte_addr = paddr[17:0];
  assign hit = (paddr[31:18] == 14'h0000) &&
               (byte_addr == guard_pkg::BOOT_RAM_CTRL_ADDR ||
                byte_addr == guard_pkg::SECURE_RAM_CTRL_ADDR ||
                byte_addr == guard_pkg::STACK_LIMIT_ADDR ||
                byte_addr == guard_pkg::STACK_PTR_ADDR ||
                byte_addr == guard_pkg::ERR_STATUS_ADDR);
  assign rd_first = psel && penable && !ack_q;
  assign wr_en = psel && penable && ack_q && pwrite && hit;
  assign pready = ack_q;
  assign pslverr = ack_q && !hit;
  assign prdata = prdata_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= rd_first;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_first) begin
      prdata_q <= 32'h0000_0000;
      case (byte_addr)
        guard_pkg::BOOT_RAM_CTRL_ADDR: prdata_q[2:0] <= boot_ctrl_q;
        guard_pkg::SECURE_RAM_CTRL_ADDR: prdata_q[2:0] <= sec_ctrl_q;
        guard_pkg::STACK_LIMIT_ADDR: prdata_q[15:0] <= stack_limit_reg;
        guard_pkg::STACK_PTR_ADDR: prdata_q[15:0] <= stack_pointer_reg;
        guard_pkg::ERR_STATUS_ADDR: prdata_q[3:0] <= err_q;
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Stack limit
  // ****************************************
  // no reset value
  // Left without reset on purpose: overflow checks are meaningless until software loads it.
  always_ff @(posedge clk) begin
    if (wr_en && byte_addr == guard_pkg::STACK_LIMIT_ADDR) begin
      stack_limit_reg <= {pwdata[15:1], 1'b0};
    end
  end

  // ****************************************
  // RAM segment controls
  // ****************************************
  // Once the lock bit is set, the guard bits hold until reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_ctrl_q <= guard_pkg::RAM_CTRL_RESET;
    end else if (wr_en && byte_addr == guard_pkg::BOOT_RAM_CTRL_ADDR &&
                 !boot_ctrl_q[guard_pkg::LOCK_BIT]) begin
      boot_ctrl_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_ctrl_q <= guard_pkg::RAM_CTRL_RESET;
    end else if (wr_en && byte_addr == guard_pkg::SECURE_RAM_CTRL_ADDR &&
                 !sec_ctrl_q[guard_pkg::LOCK_BIT]) begin
      sec_ctrl_q <= pwdata[2:0];
    end
  end

  // ****************************************
  // Stack checks
  // ****************************************
  logic [15:0] check_addr;
  logic [15:0] push_word;
  logic ovf;
  logic unf;
  logic stack_fault;

  always_comb begin
    check_addr = stack_pointer_reg;
    case (stack_op)
      guard_pkg::OP_POP: check_addr = stack_pointer_reg - guard_pkg::WORD_STEP;
      guard_pkg::OP_EA: check_addr = effective_address;
      default: check_addr = stack_pointer_reg;
    endcase
  end

  assign ovf = check_addr > stack_limit_reg;
  assign unf = check_addr < guard_pkg::STACK_FLOOR;
  assign stack_fault = stack_req && (ovf || unf);

  always_comb begin
    case (push_kind)
      guard_pkg::PUSH_CALL: push_word = {pc_msb_byte & guard_pkg::PC_MSB_MASK, push_data[7:0]};
      guard_pkg::PUSH_EXC: push_word = {status_low_byte, pc_msb_byte};
      default: push_word = push_data;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_pointer_reg <= guard_pkg::STACK_PTR_RESET;
    end else if (wr_en && byte_addr == guard_pkg::STACK_PTR_ADDR) begin
      stack_pointer_reg <= {pwdata[15:1], 1'b0};
    end else if (stack_req && !stack_fault && stack_op == guard_pkg::OP_PUSH) begin
      stack_pointer_reg <= stack_pointer_reg + guard_pkg::WORD_STEP;
    end else if (stack_req && !stack_fault && stack_op == guard_pkg::OP_POP) begin
      stack_pointer_reg <= check_addr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_mem_we <= 1'b0;
      stack_mem_re <= 1'b0;
      stack_mem_addr <= 16'h0000;
      stack_mem_wdata <= 16'h0000;
      stack_trap <= 1'b0;
    end else begin
      stack_mem_we <= stack_req && !stack_fault && stack_op == guard_pkg::OP_PUSH;
      stack_mem_re <= stack_req && !stack_fault && stack_op != guard_pkg::OP_PUSH;
      stack_mem_addr <= check_addr;
      stack_mem_wdata <= push_word;
      stack_trap <= stack_fault;
    end
  end

  // ****************************************
  // Secure RAM guard
  // ****************************************
  logic in_boot;
  logic in_sec;
  logic boot_bad;
  logic sec_bad;
  logic guard_on;

  assign in_boot = ram_addr >= BOOT_RAM_BASE && ram_addr <= BOOT_RAM_END;
  assign in_sec = ram_addr >= SECURE_RAM_BASE && ram_addr <= SECURE_RAM_END;

  always_comb begin
    guard_on = ram_write ? boot_ctrl_q[guard_pkg::WRITE_GUARD_BIT]
                         : boot_ctrl_q[guard_pkg::READ_GUARD_BIT];
    boot_bad = ram_req && in_boot && guard_on && fetch_seg != guard_pkg::SEG_BOOT;
  end

  assign sec_bad = ram_req && in_sec && fetch_seg != guard_pkg::SEG_SECURE &&
                   (ram_write ? sec_ctrl_q[guard_pkg::WRITE_GUARD_BIT]
                              : sec_ctrl_q[guard_pkg::READ_GUARD_BIT]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_grant <= 1'b0;
      ram_fault <= 1'b0;
    end else begin
      ram_grant <= ram_req && !boot_bad && !sec_bad;
      ram_fault <= boot_bad || sec_bad;
    end
  end

  // ****************************************
  // Sticky error flags
  // ****************************************
  assign err_set = {sec_bad, boot_bad, stack_req && unf, stack_req && ovf && !unf};

  // sticky flag set
  // Write one to clear; a new event in the same cycle keeps its bit set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 4'h0;
    end else if (wr_en && byte_addr == guard_pkg::ERR_STATUS_ADDR) begin
      err_q <= (err_q & ~pwdata[3:0]) | err_set;
    end else begin
      err_q <= err_q | err_set;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_push_advances: assert property (@(posedge clk) disable iff (!rst_n)
    stack_req && stack_op == guard_pkg::OP_PUSH && !stack_fault && !wr_en
    |=> stack_pointer_reg == $past(stack_pointer_reg) + guard_pkg::WORD_STEP)
    else $error("push did not advance stack pointer");

  a_pop_reads_below: assert property (@(posedge clk) disable iff (!rst_n)
    stack_req && stack_op == guard_pkg::OP_POP && !stack_fault
    |=> stack_mem_re && stack_mem_addr == $past(stack_pointer_reg) - guard_pkg::WORD_STEP)
    else $error("pop did not read below pointer");

  a_call_msb_clear: assert property (@(posedge clk) disable iff (!rst_n)
    stack_req && stack_op == guard_pkg::OP_PUSH && push_kind == guard_pkg::PUSH_CALL
    |=> !stack_mem_wdata[15])
    else $error("call push top bit not clear");

  a_exc_status_byte: assert property (@(posedge clk) disable iff (!rst_n)
    stack_req && push_kind == guard_pkg::PUSH_EXC
    |=> stack_mem_wdata[15:8] == $past(status_low_byte))
    else $error("exception push lost status byte");

  a_limit_bit0_zero: assert property (@(posedge clk) disable iff (!rst_n)
    $past(wr_en) && $past(byte_addr) == guard_pkg::STACK_LIMIT_ADDR |-> !stack_limit_reg[0])
    else $error("limit bit zero set");

  a_equal_limit_ok: assert property (@(posedge clk) disable iff (!rst_n)
    stack_req && stack_op == guard_pkg::OP_PUSH && stack_pointer_reg == stack_limit_reg &&
    !unf |=> stack_mem_we && !stack_trap)
    else $error("push at limit trapped");

  a_over_limit_trap: assert property (@(posedge clk) disable iff (!rst_n)
    stack_req && check_addr > stack_limit_reg |=> stack_trap && !stack_mem_we)
    else $error("overflow not trapped");

  a_floor_trap: assert property (@(posedge clk) disable iff (!rst_n)
    stack_req && check_addr < guard_pkg::STACK_FLOOR |=> stack_trap ##0 err_q[guard_pkg::UNF_BIT])
    else $error("underflow not trapped");

  a_boot_guard: assert property (@(posedge clk) disable iff (!rst_n)
    ram_req && in_boot && fetch_seg != guard_pkg::SEG_BOOT &&
    boot_ctrl_q[guard_pkg::READ_GUARD_BIT] && !ram_write |=> ram_fault && !ram_grant)
    else $error("boot RAM read not blocked");

  a_secure_guard: assert property (@(posedge clk) disable iff (!rst_n)
    ram_req && in_sec && fetch_seg != guard_pkg::SEG_SECURE &&
    sec_ctrl_q[guard_pkg::WRITE_GUARD_BIT] && ram_write |=> ram_fault && !ram_grant)
    else $error("secure RAM write not blocked");

  a_sticky_flag: assert property (@(posedge clk) disable iff (!rst_n)
    stack_trap && !$past(wr_en) |-> err_q[guard_pkg::OVF_BIT] || err_q[guard_pkg::UNF_BIT])
    else $error("trap left no flag");

  a_push_at_pointer: assert property (@(posedge clk) disable iff (!rst_n)
    stack_req && stack_op == guard_pkg::OP_PUSH && !stack_fault
    |=> stack_mem_we && stack_mem_addr == $past(stack_pointer_reg))
    else $error("push did not write at pointer");

  a_pop_moves_pointer: assert property (@(posedge clk) disable iff (!rst_n)
    stack_req && stack_op == guard_pkg::OP_POP && !stack_fault && !wr_en
    |=> stack_pointer_reg == $past(stack_pointer_reg) - guard_pkg::WORD_STEP)
    else $error("pop did not lower stack pointer");

  a_ea_reads_address: assert property (@(posedge clk) disable iff (!rst_n)
    stack_req && stack_op == guard_pkg::OP_EA && !stack_fault
    |=> stack_mem_re && stack_mem_addr == $past(effective_address))
    else $error("checked address not passed on");

  a_fault_blocks_access: assert property (@(posedge clk) disable iff (!rst_n)
    stack_fault |=> stack_trap && !stack_mem_we && !stack_mem_re)
    else $error("faulting access reached memory");

  a_fault_holds_pointer: assert property (@(posedge clk) disable iff (!rst_n)
    stack_fault && !wr_en |=> $stable(stack_pointer_reg))
    else $error("faulting access moved stack pointer");

  a_lock_freezes_boot: assert property (@(posedge clk) disable iff (!rst_n)
    boot_ctrl_q[guard_pkg::LOCK_BIT] |=> $stable(boot_ctrl_q))
    else $error("locked boot RAM control changed");

endmodule : stack_guard

// ---- tb/stack_mem_model.sv ----
// Purpose: Data RAM reached by the stack address generators.
// Assumes: Word-aligned stack addresses on the clk domain.
// Notes: Read data while re is low shows the inverse of the last word read.
module stack_mem_model (
  // Clock
  input wire logic clk,
  // Stack memory port
  input wire logic we,
  input wire logic re,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:32767];
  logic [15:0] last_q = 16'h5A5A;
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr[15:1]] <= wdata;
    end
    if (re) begin
      last_q <= mem[addr[15:1]];
    end
  end
  // A stale word must never pass for a pop result, so idle data is the inverse of the last word read.
  assign rdata = re ? mem[addr[15:1]] : ~last_q;
endmodule : stack_mem_model

// ---- tb/stack_limit_and_secure_ram_guard_tb_top.sv ----
// Purpose: Self-checking bench for the stack limit and secure RAM guard.
// Assumes: APB answer and one-cycle stack and RAM results as handed over.
// Notes: The stack limit is loaded before any stack traffic, since it has no reset value.
module stack_limit_and_secure_ram_guard_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic stack_req, mem_we, mem_re, trap, ram_req, ram_write, ram_grant, ram_fault;
  logic [15:0] push_data, effective_address, sp, mem_addr, mem_wdata, ram_addr, mem_rdata;
  logic [7:0] pc_msb_byte, status_low_byte;
  guard_pkg::stack_op_t stack_op;
  guard_pkg::push_kind_t push_kind;
  guard_pkg::fetch_seg_t fetch_seg;
  localparam guard_pkg::stack_op_t op_push = guard_pkg::OP_PUSH;
  localparam guard_pkg::stack_op_t op_pop = guard_pkg::OP_POP;
  localparam guard_pkg::stack_op_t op_addr = guard_pkg::OP_EA;
  localparam guard_pkg::push_kind_t k_data = guard_pkg::PUSH_DATA;
  localparam guard_pkg::fetch_seg_t s_gen = guard_pkg::SEG_GENERAL;
  localparam guard_pkg::fetch_seg_t s_boot = guard_pkg::SEG_BOOT;
  localparam guard_pkg::fetch_seg_t s_sec = guard_pkg::SEG_SECURE;
  int fail_count = 0;
  int checks = 0;

  stack_guard u_stack_guard (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stack_req(stack_req), .stack_op(stack_op), .push_kind(push_kind),
    .push_data(push_data), .pc_msb_byte(pc_msb_byte), .status_low_byte(status_low_byte),
    .effective_address(effective_address), .stack_pointer_reg(sp), .stack_mem_we(mem_we),
    .stack_mem_re(mem_re), .stack_mem_addr(mem_addr), .stack_mem_wdata(mem_wdata),
    .stack_trap(trap), .ram_req(ram_req), .ram_write(ram_write), .ram_addr(ram_addr),
    .fetch_seg(fetch_seg), .ram_grant(ram_grant), .ram_fault(ram_fault));
  stack_mem_model u_stack_mem_model (.clk(clk), .we(mem_we), .re(mem_re), .addr(mem_addr),
    .wdata(mem_wdata), .rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {14'h0000, a};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    // Read data and error are taken at the very edge that samples pready high.
    chk("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Flags are {trap, re, we}; w is the pushed word or the word a pop or an OP_EA read must return.
  task automatic st(input guard_pkg::stack_op_t op, input guard_pkg::push_kind_t k,
      input logic [15:0] d, input logic [15:0] ea, input logic [2:0] f,
      input logic [15:0] a, input logic [15:0] w, input logic [15:0] s);
    @(posedge clk);
    stack_req <= 1'b1;
    stack_op <= op;
    push_kind <= k;
    push_data <= d;
    pc_msb_byte <= d[15:8];
    status_low_byte <= d[7:0];
    effective_address <= ea;
    @(posedge clk);
    stack_req <= 1'b0;
    @(negedge clk);
    chk("stack_flags", {29'h0, trap, mem_re, mem_we}, {29'h0, f});
    if (f[1:0] != 2'b00) chk("stack_addr", {16'h0, mem_addr}, {16'h0, a});
    if (f[0]) chk("stack_wdata", {16'h0, mem_wdata}, {16'h0, w});
    if (f[1]) chk("pop_data", {16'h0, mem_rdata}, {16'h0, w});
    chk("stack_pointer", {16'h0, sp}, {16'h0, s});
  endtask : st

  task automatic ram(input logic wr, input logic [15:0] a, input guard_pkg::fetch_seg_t g,
      input logic [1:0] f);
    @(posedge clk);
    ram_req <= 1'b1;
    ram_write <= wr;
    ram_addr <= a;
    fetch_seg <= g;
    @(posedge clk);
    ram_req <= 1'b0;
    @(negedge clk);
    chk("ram_fault_grant", {30'h0, ram_fault, ram_grant}, {30'h0, f});
  endtask : ram

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    stack_req = 1'b0;
    stack_op = op_push;
    push_kind = k_data;
    push_data = 16'h0;
    pc_msb_byte = 8'h0;
    status_low_byte = 8'h0;
    effective_address = 16'h0;
    ram_req = 1'b0;
    ram_write = 1'b0;
    ram_addr = 16'h0;
    fetch_seg = s_gen;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("sp_reset", {16'h0, sp}, 32'h0800);
    apb(1'b0, guard_pkg::BOOT_RAM_CTRL_ADDR, 32'h0);
    chk("boot_ctrl_reset", rd, 32'h0);
    apb(1'b0, guard_pkg::SECURE_RAM_CTRL_ADDR, 32'h0);
    chk("secure_ctrl_reset", rd, 32'h0);
    apb(1'b0, 18'h00100, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, guard_pkg::STACK_LIMIT_ADDR, 32'h0805);
    apb(1'b0, guard_pkg::STACK_LIMIT_ADDR, 32'h0);
    chk("limit_bit0", rd, 32'h0804);
    // Pushes follow the limit write, never a pop through the stack pointer.
    st(op_push, k_data, 16'h1234, 16'h0, 3'b001, 16'h0800, 16'h1234, 16'h0802);
    st(op_push, guard_pkg::PUSH_CALL, 16'hC3AB, 16'h0, 3'b001, 16'h0802, 16'h43AB,
      16'h0804);
    st(op_push, guard_pkg::PUSH_EXC, 16'h9A5E, 16'h0, 3'b001, 16'h0804, 16'h5E9A,
      16'h0806);
    st(op_push, k_data, 16'h7777, 16'h0, 3'b100, 16'h0, 16'h0, 16'h0806);
    apb(1'b0, guard_pkg::ERR_STATUS_ADDR, 32'h0);
    chk("overflow_flag", rd, 32'h1);
    apb(1'b1, guard_pkg::ERR_STATUS_ADDR, 32'h1);
    apb(1'b0, guard_pkg::ERR_STATUS_ADDR, 32'h0);
    chk("flag_cleared", rd, 32'h0);
    st(op_pop, k_data, 16'h0, 16'h0, 3'b010, 16'h0804, 16'h5E9A, 16'h0804);
    st(op_pop, k_data, 16'h0, 16'h0, 3'b010, 16'h0802, 16'h43AB, 16'h0802);
    st(op_pop, k_data, 16'h0, 16'h0, 3'b010, 16'h0800, 16'h1234, 16'h0800);
    st(op_pop, k_data, 16'h0, 16'h0, 3'b100, 16'h0, 16'h0, 16'h0800);
    st(op_addr, k_data, 16'h0, 16'h0806, 3'b100, 16'h0, 16'h0, 16'h0800);
    st(op_addr, k_data, 16'h0, 16'h0804, 3'b010, 16'h0804, 16'h5E9A, 16'h0800);
    st(op_addr, k_data, 16'h0, 16'h07FE, 3'b100, 16'h0, 16'h0, 16'h0800);
    apb(1'b0, guard_pkg::ERR_STATUS_ADDR, 32'h0);
    chk("both_flags", rd, 32'h3);
    apb(1'b1, guard_pkg::ERR_STATUS_ADDR, 32'hF);
    apb(1'b1, guard_pkg::BOOT_RAM_CTRL_ADDR, 32'h6);
    apb(1'b1, guard_pkg::SECURE_RAM_CTRL_ADDR, 32'h2);
    ram(1'b0, 16'h0810, s_gen, 2'b10);
    ram(1'b1, 16'h0800, s_sec, 2'b10);
    ram(1'b1, 16'h08FF, s_boot, 2'b01);
    ram(1'b0, 16'h0910, s_boot, 2'b10);
    ram(1'b1, 16'h0910, s_gen, 2'b01);
    ram(1'b0, 16'h09FF, s_sec, 2'b01);
    ram(1'b0, 16'h0A00, s_gen, 2'b01);
    apb(1'b0, guard_pkg::ERR_STATUS_ADDR, 32'h0);
    chk("guard_flags", rd, 32'hC);
    apb(1'b1, guard_pkg::BOOT_RAM_CTRL_ADDR, 32'h1);
    apb(1'b1, guard_pkg::BOOT_RAM_CTRL_ADDR, 32'h6);
    apb(1'b0, guard_pkg::BOOT_RAM_CTRL_ADDR, 32'h0);
    chk("lock_holds", rd, 32'h1);
    ram(1'b0, 16'h0810, s_gen, 2'b01);
    apb(1'b1, guard_pkg::STACK_PTR_ADDR, 32'h0901);
    @(negedge clk);
    chk("sp_written", {16'h0, sp}, 32'h0900);
    finish_test();
  end

  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule : stack_limit_and_secure_ram_guard_tb_top
